// File: host_port_pkg.sv
// constants and types for the host-side controller of the word-wide cpu port
// Operation
// - every transfer is a whole 16-bit word; byte-select bit is never driven
// - a 20-bit word address goes out on address lines 20 down to 1
// - space select low reaches registers, high reaches external memory
// - indirect access: load address and write data, then launch by command
// - completion clears the pending bit and may raise an interrupt; host polls
// - after an indirect read the fetched word waits in the data register
// - writing 0001h to the chip reset register starts a software reset
// - the host holds the reset pin low at least 100 ns
// - wait 2 us after reset release, clear reset register, then others
// - program configuration fields before setting any process enable bits
package host_port_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;

  // byte offsets of the device registers
  localparam logic [ADDR_W:0] CHIP_RESET_OFS = 21'h000000;
  localparam logic [ADDR_W:0] MAIN_STATUS_OFS = 21'h000002;
  localparam logic [ADDR_W:0] IND_ADDR_LO_OFS = 21'h000004;
  localparam logic [ADDR_W:0] IND_CMD_OFS = 21'h000006;
  localparam logic [ADDR_W:0] IND_DATA_OFS = 21'h000008;
  localparam logic [ADDR_W:0] IRQ_MASK_OFS = 21'h00000A;

  // word addresses as driven on address lines 20..1
  localparam logic [ADDR_W-1:0] CHIP_RESET_WADDR = CHIP_RESET_OFS[ADDR_W:1];
  localparam logic [ADDR_W-1:0] MAIN_STATUS_WADDR = MAIN_STATUS_OFS[ADDR_W:1];
  localparam logic [ADDR_W-1:0] IND_ADDR_LO_WADDR = IND_ADDR_LO_OFS[ADDR_W:1];
  localparam logic [ADDR_W-1:0] IND_CMD_WADDR = IND_CMD_OFS[ADDR_W:1];
  localparam logic [ADDR_W-1:0] IND_DATA_WADDR = IND_DATA_OFS[ADDR_W:1];
  localparam logic [ADDR_W-1:0] IRQ_MASK_WADDR = IRQ_MASK_OFS[ADDR_W:1];

  // chip reset register values
  localparam logic [DATA_W-1:0] CHIP_RESET_SET = 16'h0001;
  localparam logic [DATA_W-1:0] CHIP_RESET_CLEAR = 16'h0000;

  // indirect command register fields
  localparam int IND_PEND_BIT = 15;
  localparam int IND_READ_BIT = 14;
  localparam int IND_EXT_BIT = 12;
  localparam int IND_UPPER_W = 4;
  localparam int IND_LO_W = 16;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 100;
  localparam int RESET_RECOVER_US = 2;
  localparam int NS_PER_US = 1000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVER_CYC =
    (RESET_RECOVER_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  // bus timing style strap codes
  localparam logic STYLE_A = 1'b0;
  localparam logic STYLE_B = 1'b1;

  typedef enum logic [3:0] {
    S_HW_LOAD = 4'h0,
    S_HW_RST = 4'h1,
    S_REC_LOAD = 4'h2,
    S_RECOVER = 4'h3,
    S_CLEAR = 4'h4,
    S_IDLE = 4'h5,
    S_ACC = 4'h6,
    S_ACC_END = 4'h7,
    S_IND_LO = 4'h8,
    S_IND_CMD = 4'h9,
    S_IND_POLL = 4'hA,
    S_IND_CHECK = 4'hB,
    S_DONE = 4'hC
  } ctrl_state_t;

endpackage : host_port_pkg

// File: pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = rst_b ? pin : RESET_VAL;
    next_sync = rst_b ? stage1 : RESET_VAL;
  end

  always_ff @(posedge ref_clk) begin
    stage1 <= next_stage1;
    sync <= next_sync;
  end

endmodule : pin_sync
`default_nettype wire

// File: cycle_timer.sv
// loadable down-counter that flags when it has run out
`timescale 1ns/1ns
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (!rst_b) begin
      next_count = '0;
    end else if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    count <= next_count;
  end

  assign done = (count == '0) && !load;

endmodule : cycle_timer
`default_nettype wire

// File: host_cpu_port_ctrl.sv
// host controller that drives the device's word-wide cpu port and reset pin and watches its interrupt pin
`timescale 1ns/1ns
`default_nettype none
module host_cpu_port_ctrl #(
  parameter logic BUS_STYLE = host_port_pkg::STYLE_A,
  parameter int HOLD_CYC = host_port_pkg::RESET_HOLD_CYC,
  parameter int RECOVER_CYC = host_port_pkg::RESET_RECOVER_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // user side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_indirect,
  input wire logic cmd_ext,
  input wire logic [host_port_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [host_port_pkg::DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [host_port_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic hw_reset_req,
  input wire logic sw_reset_req,
  output logic in_reset,
  output logic irq_active,
  // device side
  output logic dev_reset_b,
  output logic bus_style_strap,
  output logic [host_port_pkg::ADDR_W-1:0] cpu_addr,
  output logic external_space_select,
  output logic cpu_sel_b,
  output logic cpu_write,
  output logic [host_port_pkg::DATA_W-1:0] cpu_wdata,
  output logic cpu_data_oe,
  input wire logic [host_port_pkg::DATA_W-1:0] cpu_rdata_pin,
  input wire logic cpu_ready_pin,
  input wire logic irq_b_pin
);

  localparam int DW = host_port_pkg::DATA_W;
  localparam int AW = host_port_pkg::ADDR_W;
  localparam int TW = host_port_pkg::TIMER_W;
  localparam logic [TW-1:0] HOLD_LOAD = TW'(HOLD_CYC);
  localparam logic [TW-1:0] RECOVER_LOAD = TW'(RECOVER_CYC);

  host_port_pkg::ctrl_state_t state;
  host_port_pkg::ctrl_state_t next_state;
  host_port_pkg::ctrl_state_t ret;
  host_port_pkg::ctrl_state_t next_ret;

  logic next_dev_reset_b;
  logic [AW-1:0] next_cpu_addr;
  logic next_space;
  logic next_sel_b;
  logic next_cpu_write;
  logic [DW-1:0] next_cpu_wdata;
  logic next_data_oe;
  logic [DW-1:0] next_rsp_rdata;

  // latched user operation
  logic op_write;
  logic next_op_write;
  logic op_ext;
  logic next_op_ext;
  logic [AW-1:0] op_addr;
  logic [AW-1:0] next_op_addr;

  // access launch request built inside the case
  logic go_acc;
  logic acc_write;
  logic acc_ext;
  logic [AW-1:0] acc_addr;
  logic [DW-1:0] acc_data;

  logic timer_load;
  logic [TW-1:0] timer_value;
  logic timer_done;

  logic ready_sync;
  logic irq_b_sync;
  logic [DW-1:0] rdata_sync;

  pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_ready_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(cpu_ready_pin),
    .sync(ready_sync)
  );

  // a floating interrupt pin reads high through the board pull-up
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_irq_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(irq_b_pin),
    .sync(irq_b_sync)
  );

  pin_sync #(.WIDTH(DW), .RESET_VAL('0)) u_rdata_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(cpu_rdata_pin),
    .sync(rdata_sync)
  );

  cycle_timer #(.WIDTH(TW)) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    next_ret = ret;
    next_dev_reset_b = dev_reset_b;
    next_cpu_addr = cpu_addr;
    next_space = external_space_select;
    next_sel_b = cpu_sel_b;
    next_cpu_write = cpu_write;
    next_cpu_wdata = cpu_wdata;
    next_data_oe = cpu_data_oe;
    next_rsp_rdata = rsp_rdata;
    next_op_write = op_write;
    next_op_ext = op_ext;
    next_op_addr = op_addr;
    go_acc = 1'b0;
    acc_write = 1'b0;
    acc_ext = 1'b0;
    acc_addr = '0;
    acc_data = '0;
    timer_load = 1'b0;
    timer_value = '0;

    unique case (state)
      host_port_pkg::S_HW_LOAD: begin
        next_dev_reset_b = 1'b0;
        timer_load = 1'b1;
        timer_value = HOLD_LOAD;
        next_state = host_port_pkg::S_HW_RST;
      end
      host_port_pkg::S_HW_RST: begin
        // pin stays low until the hold count runs out
        if (timer_done) begin
          next_dev_reset_b = 1'b1;
          next_state = host_port_pkg::S_REC_LOAD;
        end
      end
      host_port_pkg::S_REC_LOAD: begin
        timer_load = 1'b1;
        timer_value = RECOVER_LOAD;
        next_state = host_port_pkg::S_RECOVER;
      end
      host_port_pkg::S_RECOVER: begin
        if (timer_done) begin
          next_state = host_port_pkg::S_CLEAR;
        end
      end
      host_port_pkg::S_CLEAR: begin
        // only the chip reset register is touched until it has been written clear
        go_acc = 1'b1;
        acc_write = 1'b1;
        acc_addr = host_port_pkg::CHIP_RESET_WADDR;
        acc_data = host_port_pkg::CHIP_RESET_CLEAR;
        // nothing else is written on our own; config-before-enable order stays with the user
        next_ret = host_port_pkg::S_IDLE;
      end
      host_port_pkg::S_IDLE: begin
        if (hw_reset_req) begin
          next_state = host_port_pkg::S_HW_LOAD;
        end else if (sw_reset_req) begin
          go_acc = 1'b1;
          acc_write = 1'b1;
          acc_addr = host_port_pkg::CHIP_RESET_WADDR;
          acc_data = host_port_pkg::CHIP_RESET_SET;
          next_ret = host_port_pkg::S_REC_LOAD;
        end else if (cmd_valid) begin
          next_op_write = cmd_write;
          next_op_ext = cmd_ext;
          next_op_addr = cmd_addr;
          if (!cmd_indirect) begin
            // direct access; completion waits on the device ready
            go_acc = 1'b1;
            acc_write = cmd_write;
            acc_ext = cmd_ext;
            acc_addr = cmd_addr;
            acc_data = cmd_wdata;
            next_ret = host_port_pkg::S_DONE;
          end else if (cmd_write) begin
            // write data is staged before the address and launch
            go_acc = 1'b1;
            acc_write = 1'b1;
            acc_addr = host_port_pkg::IND_DATA_WADDR;
            acc_data = cmd_wdata;
            next_ret = host_port_pkg::S_IND_LO;
          end else begin
            next_state = host_port_pkg::S_IND_LO;
          end
        end
      end
      host_port_pkg::S_IND_LO: begin
        go_acc = 1'b1;
        acc_write = 1'b1;
        acc_addr = host_port_pkg::IND_ADDR_LO_WADDR;
        acc_data = op_addr[host_port_pkg::IND_LO_W-1:0];
        next_ret = host_port_pkg::S_IND_CMD;
      end
      host_port_pkg::S_IND_CMD: begin
        go_acc = 1'b1;
        acc_write = 1'b1;
        acc_addr = host_port_pkg::IND_CMD_WADDR;
        acc_data = '0;
        acc_data[host_port_pkg::IND_UPPER_W-1:0] = op_addr[AW-1:host_port_pkg::IND_LO_W];
        acc_data[host_port_pkg::IND_EXT_BIT] = op_ext;
        acc_data[host_port_pkg::IND_READ_BIT] = !op_write;
        acc_data[host_port_pkg::IND_PEND_BIT] = 1'b1;
        next_ret = host_port_pkg::S_IND_POLL;
      end
      host_port_pkg::S_IND_POLL: begin
        go_acc = 1'b1;
        acc_addr = host_port_pkg::IND_CMD_WADDR;
        next_ret = host_port_pkg::S_IND_CHECK;
      end
      host_port_pkg::S_IND_CHECK: begin
        // no new launch until the pending bit reads clear
        if (rsp_rdata[host_port_pkg::IND_PEND_BIT]) begin
          next_state = host_port_pkg::S_IND_POLL;
        end else if (op_write) begin
          next_state = host_port_pkg::S_DONE;
        end else begin
          go_acc = 1'b1;
          acc_addr = host_port_pkg::IND_DATA_WADDR;
          next_ret = host_port_pkg::S_DONE;
        end
      end
      host_port_pkg::S_ACC: begin
        if (ready_sync) begin
          next_rsp_rdata = rdata_sync;
          next_sel_b = 1'b1;
          next_data_oe = 1'b0;
          next_state = host_port_pkg::S_ACC_END;
        end
      end
      host_port_pkg::S_ACC_END: begin
        // the device must drop ready before the next strobe
        if (!ready_sync) begin
          next_state = ret;
        end
      end
      host_port_pkg::S_DONE: begin
        next_state = host_port_pkg::S_IDLE;
      end
      default: begin
        next_state = host_port_pkg::S_HW_LOAD;
      end
    endcase

    if (go_acc) begin
      // whole-word transfer on lines 20..1; no byte select exists
      next_cpu_addr = acc_addr;
      next_space = acc_ext;
      next_sel_b = 1'b0;
      next_cpu_write = acc_write;
      next_cpu_wdata = acc_data;
      next_data_oe = acc_write;
      next_state = host_port_pkg::S_ACC;
    end

    if (!rst_b) begin
      next_state = host_port_pkg::S_HW_LOAD;
      next_ret = host_port_pkg::S_IDLE;
      next_dev_reset_b = 1'b0;
      next_cpu_addr = '0;
      next_space = 1'b0;
      next_sel_b = 1'b1;
      next_cpu_write = 1'b0;
      next_cpu_wdata = '0;
      next_data_oe = 1'b0;
      next_rsp_rdata = '0;
      next_op_write = 1'b0;
      next_op_ext = 1'b0;
      next_op_addr = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
    ret <= next_ret;
    dev_reset_b <= next_dev_reset_b;
    cpu_addr <= next_cpu_addr;
    external_space_select <= next_space;
    cpu_sel_b <= next_sel_b;
    cpu_write <= next_cpu_write;
    cpu_wdata <= next_cpu_wdata;
    cpu_data_oe <= next_data_oe;
    rsp_rdata <= next_rsp_rdata;
    op_write <= next_op_write;
    op_ext <= next_op_ext;
    op_addr <= next_op_addr;
  end

  assign cmd_ready = (state == host_port_pkg::S_IDLE) && !hw_reset_req && !sw_reset_req;
  assign rsp_valid = (state == host_port_pkg::S_DONE);
  assign in_reset = (state == host_port_pkg::S_HW_LOAD) || (state == host_port_pkg::S_HW_RST)
    || (state == host_port_pkg::S_REC_LOAD) || (state == host_port_pkg::S_RECOVER)
    || (state == host_port_pkg::S_CLEAR) || ((state == host_port_pkg::S_ACC ||
    state == host_port_pkg::S_ACC_END) && ret == host_port_pkg::S_REC_LOAD);
  // a low pin means some enabled module request is active
  assign irq_active = !irq_b_sync;
  assign bus_style_strap = BUS_STYLE;

endmodule : host_cpu_port_ctrl
`default_nettype wire

// File: host_cpu_port_ctrl_checker.sv
// assertion checker for the host cpu port controller
`timescale 1ns/1ns
`default_nettype none
module host_cpu_port_ctrl_checker #(
  parameter int HOLD_CYC = 10,
  parameter int RECOVER_CYC = 200
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic in_reset,
  input wire logic irq_active,
  input wire logic dev_reset_b,
  input wire logic [host_port_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic external_space_select,
  input wire logic cpu_sel_b,
  input wire logic cpu_write,
  input wire logic [host_port_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic cpu_data_oe,
  input wire logic cpu_ready_pin,
  input wire logic irq_b_pin
);
  logic [15:0] low_cnt, rel_cnt, next_low_cnt, next_rel_cnt;
  logic first, next_first;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // low time of the reset pin, time since its release, first strobe pending
  always_comb begin
    next_low_cnt = dev_reset_b ? 16'h0000 : low_cnt + 16'h0001;
    next_rel_cnt = (rel_cnt == 16'hFFFF) ? rel_cnt : rel_cnt + 16'h0001;
    if (!dev_reset_b) next_rel_cnt = 16'h0000;
    next_first = !dev_reset_b || (first && cpu_sel_b);
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      low_cnt <= 16'h0000;
      rel_cnt <= 16'h0000;
      first <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      rel_cnt <= next_rel_cnt;
      first <= next_first;
    end
  end
  property p_hold_low;
    $rose(dev_reset_b) |-> low_cnt >= HOLD_CYC;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("reset pin released early");
  property p_recover;
    !cpu_sel_b |-> rel_cnt >= RECOVER_CYC;
  endproperty
  a_recover: assert property (p_recover) else $error("strobe too soon after reset");
  property p_first_clear;
    !cpu_sel_b && first |-> cpu_write && !external_space_select &&
      cpu_addr == host_port_pkg::CHIP_RESET_WADDR && cpu_wdata == host_port_pkg::CHIP_RESET_CLEAR;
  endproperty
  a_first_clear: assert property (p_first_clear) else $error("first access not clear");
  property p_strobe_hold;
    !cpu_sel_b && !cpu_ready_pin && !$past(cpu_ready_pin) && !$past(cpu_ready_pin, 2)
      |=> !cpu_sel_b;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe dropped early");
  property p_addr_stable;
    !cpu_sel_b && !$past(cpu_sel_b) |-> $stable(cpu_addr) && $stable(cpu_write) &&
      $stable(external_space_select) && $stable(cpu_wdata);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("access changed");
  property p_oe;
    cpu_data_oe == (!cpu_sel_b && cpu_write);
  endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");
  property p_reset_busy;
    !dev_reset_b || in_reset |-> !cmd_ready;
  endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("ready in reset");
  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");
  property p_irq_on;
    !irq_b_pin [*3] |=> irq_active;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missed");
  property p_irq_off;
    irq_b_pin [*3] |=> !irq_active;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt stuck");
endmodule : host_cpu_port_ctrl_checker
bind host_cpu_port_ctrl host_cpu_port_ctrl_checker #(.HOLD_CYC(HOLD_CYC),
  .RECOVER_CYC(RECOVER_CYC)) chk (.*);
`default_nettype wire

// File: cpu_dev_model.sv
// behavioural model of the device behind the word-wide cpu port
`timescale 1ns/1ns
`default_nettype none
module cpu_dev_model (
  input wire logic ref_clk,
  input wire logic reset_b,
  input wire logic [19:0] addr,
  input wire logic space,
  input wire logic sel_b,
  input wire logic write,
  input wire logic [15:0] wdata,
  input wire logic [15:0] mod_req,
  input wire logic [3:0] wait_cyc,
  output logic [15:0] rdata,
  output logic ready,
  output logic irq_low
);
  logic [15:0] mem [0:255];
  logic [15:0] regs [0:7];
  logic [3:0] cnt;
  logic [2:0] busy;
  logic [2:0] ra;
  assign ra = addr[2:0];
  assign irq_low = |(mod_req & regs[5]);
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  always @(posedge ref_clk) begin
    if (busy == 3'h1) begin
      if (regs[3][14]) regs[4] <= mem[regs[2][7:0]];
      else mem[regs[2][7:0]] <= regs[4];
      regs[3][15] <= 1'b0;
    end
    if (busy != 3'h0) busy <= busy - 3'h1;
    if (!reset_b) begin
      regs[0] <= 16'h0001;
      for (int i = 1; i < 8; i++) regs[i] <= 16'h0000;
      busy <= 3'h0;
      ready <= 1'b0;
      rdata <= 16'h5A5A;
    end else if (sel_b) begin
      ready <= 1'b0;
      cnt <= 4'h0;
      // a released bus inverts the data word on every cycle
      rdata <= ~rdata;
    end else if (cnt != wait_cyc) begin
      cnt <= cnt + 4'h1;
    end else if (!ready) begin
      ready <= 1'b1;
      if (space) begin
        rdata <= mem[addr[7:0]];
        if (write) mem[addr[7:0]] <= wdata;
      end else if (regs[0][0] && ra != 3'h0) rdata <= 16'hFFFF;
      else if (!write) rdata <= (ra == 3'h1) ? mod_req : regs[ra];
      else if (ra == 3'h3) begin
        if (!regs[3][15] && wdata[15]) busy <= 3'h4;
        if (!regs[3][15]) regs[3] <= wdata;
      end else if (ra != 3'h1) regs[ra] <= wdata;
    end
  end
endmodule : cpu_dev_model
`default_nettype wire

// File: test_host_cpu_port_reset_irq.sv
// self-checking bench for the host cpu port controller
`timescale 1ns/1ns
`default_nettype none
module test_host_cpu_port_reset_irq;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_indirect = 1'b0, cmd_ext = 1'b0;
  logic hw_reset_req = 1'b0, sw_reset_req = 1'b0;
  logic [19:0] cmd_addr = 20'h00000;
  logic [15:0] cmd_wdata = 16'h0000, mod_req = 16'h0000;
  logic [3:0] wait_cyc = 4'h0;
  logic cmd_ready, rsp_valid, in_reset, irq_active, dev_reset_b, bus_style_strap;
  logic external_space_select, cpu_sel_b, cpu_write, cpu_data_oe, cpu_ready_pin, irq_low;
  logic irq_b_pin;
  logic [19:0] cpu_addr;
  logic [15:0] rsp_rdata, cpu_wdata, cpu_rdata_pin, q;
  int mismatches = 0, n_tests = 0;
  // pull-up on the open-drain interrupt line
  assign irq_b_pin = irq_low ? 1'b0 : 1'b1;
  host_cpu_port_ctrl dut (.*);
  cpu_dev_model dev (.ref_clk(ref_clk), .reset_b(dev_reset_b), .addr(cpu_addr),
    .space(external_space_select), .sel_b(cpu_sel_b), .write(cpu_write), .wdata(cpu_wdata),
    .mod_req(mod_req), .wait_cyc(wait_cyc), .rdata(cpu_rdata_pin), .ready(cpu_ready_pin),
    .irq_low(irq_low));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_idle;
    for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    check("idle", {15'h0000, cmd_ready}, 16'h0001);
  endtask : wait_idle
  task automatic op(input logic w, input logic ind, input logic ext, input logic [19:0] a,
    input logic [15:0] d);
    wait_idle();
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_indirect <= ind;
    cmd_ext <= ext;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
    if (!ind) begin
      check("addr", cpu_addr[15:0], a[15:0]);
      check("addr top", {12'h000, cpu_addr[19:16]}, {12'h000, a[19:16]});
      check("space", {15'h0000, external_space_select}, {15'h0000, ext});
    end
    for (int n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
    check("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    q = rsp_rdata;
  endtask : op
  task automatic req_reset(input logic hw);
    wait_idle();
    @(posedge ref_clk);
    hw_reset_req <= hw;
    sw_reset_req <= !hw;
    for (int n = 0; n < 50 && in_reset !== 1'b1; n++) @(negedge ref_clk);
    check("in_reset", {15'h0000, in_reset}, 16'h0001);
    @(posedge ref_clk);
    hw_reset_req <= 1'b0;
    sw_reset_req <= 1'b0;
    wait_idle();
  endtask : req_reset
  task automatic t_startup;
    wait_idle();
    check("strap", {15'h0000, bus_style_strap}, {15'h0000, host_port_pkg::STYLE_A});
    op(1'b0, 1'b0, 1'b0, host_port_pkg::CHIP_RESET_WADDR, 16'h0000);
    check("reset latch", q, host_port_pkg::CHIP_RESET_CLEAR);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0000);
    check("mask reset", q, 16'h0000);
  endtask : t_startup
  task automatic t_regs;
    mod_req <= 16'h8001;
    for (int i = 0; i < 2; i++) begin
      wait_cyc <= i ? 4'h9 : 4'h0;
      op(1'b1, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h5A00);
      op(1'b0, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0000);
      check("mask", q, 16'h5A00);
      op(1'b1, 1'b0, 1'b0, host_port_pkg::MAIN_STATUS_WADDR, 16'h1234);
      op(1'b0, 1'b0, 1'b0, host_port_pkg::MAIN_STATUS_WADDR, 16'h0000);
      check("status", q, 16'h8001);
    end
    mod_req <= 16'h0000;
  endtask : t_regs
  task automatic t_ext;
    op(1'b1, 1'b0, 1'b1, 20'hFFFFF, 16'h3C3C);
    op(1'b1, 1'b0, 1'b1, host_port_pkg::IRQ_MASK_WADDR, 16'h7E7E);
    op(1'b0, 1'b0, 1'b1, 20'hFFFFF, 16'h0000);
    check("ext word", q, 16'h3C3C);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0000);
    check("reg space", q, 16'h5A00);
  endtask : t_ext
  task automatic t_indirect;
    wait_cyc <= 4'h9;
    op(1'b1, 1'b1, 1'b1, 20'h00034, 16'hBEEF);
    op(1'b0, 1'b0, 1'b1, 20'h00034, 16'h0000);
    check("ind write", q, 16'hBEEF);
    op(1'b1, 1'b0, 1'b1, 20'h000C8, 16'h0F0F);
    op(1'b0, 1'b1, 1'b1, 20'h000C8, 16'h0000);
    check("ind read", q, 16'h0F0F);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::IND_CMD_WADDR, 16'h0000);
    check("pending", {15'h0000, q[host_port_pkg::IND_PEND_BIT]}, 16'h0000);
    wait_cyc <= 4'h2;
  endtask : t_indirect
  task automatic t_irq;
    mod_req <= 16'h0004;
    op(1'b1, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0000);
    repeat (4) @(negedge ref_clk);
    check("irq masked", {15'h0000, irq_active}, 16'h0000);
    op(1'b1, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0004);
    repeat (4) @(negedge ref_clk);
    check("irq on", {15'h0000, irq_active}, 16'h0001);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::MAIN_STATUS_WADDR, 16'h0000);
    check("irq status", q, 16'h0004);
    mod_req <= 16'h0000;
    repeat (4) @(negedge ref_clk);
    check("irq off", {15'h0000, irq_active}, 16'h0000);
  endtask : t_irq
  task automatic t_resets;
    req_reset(1'b0);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::CHIP_RESET_WADDR, 16'h0000);
    check("sw reset latch", q, 16'h0000);
    req_reset(1'b1);
    op(1'b0, 1'b0, 1'b0, host_port_pkg::IRQ_MASK_WADDR, 16'h0000);
    check("hw reset mask", q, 16'h0000);
  endtask : t_resets
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_startup();
    t_regs();
    t_ext();
    t_indirect();
    t_irq();
    t_resets();
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
endmodule : test_host_cpu_port_reset_irq
`default_nettype wire
